// File: verilog/sound_ctl_map.vh
// register offsets, codes, states and field positions of the sound control block
`ifndef SOUND_CTL_MAP_VH
`define SOUND_CTL_MAP_VH

// ****************************************
// register byte offsets
// ****************************************
`define OFS_REQ_CODE     8'h00
`define OFS_REQ_INDEX    8'h04
`define OFS_REQ_ARG0     8'h08
`define OFS_REQ_ARG1     8'h0c
`define OFS_REQ_ARG2     8'h10
`define OFS_REQ_ARG3     8'h14
`define OFS_REQ_GO       8'h18
`define OFS_RSP_STATUS   8'h1c
`define OFS_RSP_W0       8'h20
`define OFS_RSP_W7       8'h3c
`define OFS_EVT_TYPE     8'h40
`define OFS_EVT_DATA     8'h44
`define OFS_EVT_CTRL     8'h48
`define OFS_STRM_STATE   8'h4c

// ****************************************
// request, event and status codes
// ****************************************
`define R_JACK_INFO      32'h0000_0001
`define R_JACK_REMAP     32'h0000_0002
`define R_PCM_INFO       32'h0000_0100
`define R_PCM_SET_PARAMS 32'h0000_0101
`define R_PCM_PREPARE    32'h0000_0102
`define R_PCM_RELEASE    32'h0000_0103
`define R_PCM_START      32'h0000_0104
`define R_PCM_STOP       32'h0000_0105
`define EVT_JACK_CONN    32'h0000_1000
`define EVT_JACK_DISC    32'h0000_1001
`define S_OK             16'h8000
`define S_BAD_MSG        16'h8001
`define S_NOT_SUPP       16'h8002
`define S_IO_ERR         16'h8003

// ****************************************
// fields, masks and reset values
// ****************************************
`define JACK_F_REMAP     0
`define PCM_F_SHMEM_HOST 0
`define PCM_F_SHMEM_GST  1
`define PCM_F_POLLING    2
`define PCM_F_DEFINED    32'h0000_001f
`define PCM_RATE_DEFINED 64'h0000_0000_0000_ffff
`define RSP_BUSY_BIT     31
`define EVT_PEND_BIT     0
`define RST_STATUS       32'h0000_0000

// ****************************************
// stream states
// ****************************************
`define ST_RELEASED      3'h0
`define ST_PARAMS        3'h1
`define ST_PREPARED      3'h2
`define ST_RUNNING       3'h3
`define ST_STOPPED       3'h4

`endif

// File: verilog/sound_jack_pcm_control.v
// control message handler for jacks and pcm streams of a virtual sound device, apb slave
//
// How it works
// - jack info answer: header, features, defconf, caps, connected byte, seven zero pads.
// - remap support is feature bit zero, one-hot shifted by index.
// - connected byte reads one when plugged, zero when unplugged.
// - no jack feature bit other than remap is ever set.
// - plug or unplug posts connect or disconnect event carrying jack index.
// - pcm requests carry code then stream index below stream count.
// - params state allows set or prepare; prepared allows set, prepare, start, release.
// - running allows stop; stopped allows start or release; released allows set, prepare.
// - stream info: header, features, formats, rates, direction, channel limits, five pads.
// - stream feature bits zero to four: host shm, guest shm, polling, periods, xruns.
// - rate codes index the sixteen frame rates in the fixed order.
// - only interleaved sample layout is handled.
// - stream info holds only defined feature, format, rate and direction values.
// - set params carries buffer, period, features, channels, format and rate.
// - polling selected suppresses queue notifications; device polls queues instead.
// - intermediate buffer must hold at least the requested buffer bytes.
// - request codes: jack info 1, remap 2, pcm info 0x0100 onward.
// - every answer carries status: ok 0x8000, bad msg, not supp, io err.
// - jack connect event 0x1000, disconnect 0x1001.
// - release completes only after all pending transfers of the stream end.
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ps
`include "sound_ctl_map.vh"

module sound_jack_pcm_control #(
	parameter                 NJACK       = 2,
	parameter                 NSTREAM     = 2,
	parameter [31:0]          BUF_CAP     = 32'h0001_0000,
	parameter [31:0]          FN_NID      = 32'h0000_0001,
	parameter [31:0]          JACK_DEFCFG = 32'h0000_0000,
	parameter [31:0]          JACK_CAPS   = 32'h0000_0000,
	parameter                 JACK_REMAP  = 1,
	parameter [31:0]          PCM_FEAT    = 32'h0000_001c,
	parameter [63:0]          PCM_FMTS    = 64'h0000_0000_0000_0004,
	parameter [63:0]          FMT_DEFINED = 64'h0000_0000_00ff_ffff,
	parameter [63:0]          PCM_RATES   = 64'h0000_0000_0000_00c0,
	parameter [7:0]           CH_MIN      = 8'h01,
	parameter [7:0]           CH_MAX      = 8'h02,
	parameter [NSTREAM-1:0]   DIR_MASK    = 2'h2
)(
	// clock and reset
	input  wire               mclk,
	input  wire               srst,
	// apb slave
	input  wire               psel,
	input  wire               penable,
	input  wire               pwrite,
	input  wire [7:0]         paddr,
	input  wire [31:0]        pwdata,
	output reg  [31:0]        prdata,
	output wire               pready,
	output wire               pslverr,
	// jack plug pins
	input  wire [NJACK-1:0]   jack_plug,
	// stream data path
	input  wire [NSTREAM-1:0] xfer_pending,
	output reg  [NSTREAM-1:0] stream_run,
	output reg  [NSTREAM-1:0] tx_accept,
	output reg  [NSTREAM-1:0] poll_mode,
	// jack remap
	output reg                remap_strobe,
	output reg  [31:0]        remap_jack,
	output reg  [31:0]        remap_assoc,
	output reg  [31:0]        remap_seq
);

	// ****************************************
	// storage
	// ****************************************
	reg  [31:0]        req_code_reg;
	reg  [31:0]        req_index_reg;
	reg  [31:0]        req_arg0_reg;
	reg  [31:0]        req_arg1_reg;
	reg  [31:0]        req_arg2_reg;
	reg  [31:0]        req_arg3_reg;
	reg  [31:0]        status_reg;
	reg  [31:0]        rsp_reg [0:7];
	reg  [2:0]         st_reg [0:NSTREAM-1];
	reg  [31:0]        feat_reg [0:NSTREAM-1];
	reg  [NJACK-1:0]   s1_reg;
	reg  [NJACK-1:0]   s2_reg;
	reg  [NJACK-1:0]   s3_reg;
	reg  [NJACK-1:0]   plug_reg;
	reg  [NJACK-1:0]   told_reg;
	reg                evt_valid_reg;
	reg  [31:0]        evt_type_reg;
	reg  [31:0]        evt_data_reg;
	reg  [31:0]        rd_next;
	reg                rd_hit;
	reg                ev_hit;
	reg  [31:0]        ev_sel;
	integer            i;
	// each process keeps its own loop index so no variable has two drivers
	integer            jx;
	integer            sx;

	wire               busy      = status_reg[`RSP_BUSY_BIT];
	wire               acc       = psel & penable;
	wire               wr        = acc & pwrite;
	wire               go        = wr & (paddr == `OFS_REQ_GO) & ~busy;
	wire               jack_ok   = req_index_reg < NJACK;
	wire               strm_ok   = req_index_reg < NSTREAM;
	wire [2:0]         cur_st    = strm_ok ? st_reg[req_index_reg] : `ST_RELEASED;
	// advertised values are masked so undefined bits can never leak out
	// defined values only
	wire [31:0]        adv_feat  = PCM_FEAT & `PCM_F_DEFINED;
	wire [63:0]        adv_fmts  = PCM_FMTS & FMT_DEFINED;
	wire [63:0]        adv_rates = PCM_RATES & `PCM_RATE_DEFINED;
	wire [31:0]        jack_feat = (JACK_REMAP != 0) ? (32'h0000_0001 << `JACK_F_REMAP) : 32'h0000_0000;
	wire [7:0]         sp_ch     = req_arg3_reg[7:0];
	wire [7:0]         sp_fmt    = req_arg3_reg[15:8];
	wire [7:0]         sp_rate   = req_arg3_reg[23:16];

	// ****************************************
	// apb read path
	// ****************************************
	assign pready  = 1'b1;
	assign pslverr = acc & ~rd_hit;

	always @*
	begin
		rd_hit  = 1'b1;
		rd_next = 32'h0000_0000;
		case (paddr)
			`OFS_REQ_CODE:   rd_next = req_code_reg;
			`OFS_REQ_INDEX:  rd_next = req_index_reg;
			`OFS_REQ_ARG0:   rd_next = req_arg0_reg;
			`OFS_REQ_ARG1:   rd_next = req_arg1_reg;
			`OFS_REQ_ARG2:   rd_next = req_arg2_reg;
			`OFS_REQ_ARG3:   rd_next = req_arg3_reg;
			`OFS_REQ_GO:     rd_next = 32'h0000_0000;
			`OFS_RSP_STATUS: rd_next = status_reg;
			`OFS_EVT_TYPE:   rd_next = evt_type_reg;
			`OFS_EVT_DATA:   rd_next = evt_data_reg;
			`OFS_EVT_CTRL:   rd_next = {31'h0000_0000, evt_valid_reg};
			`OFS_STRM_STATE: rd_next = {29'h0000_0000, cur_st};
			default:
			begin
				if (paddr >= `OFS_RSP_W0 && paddr <= `OFS_RSP_W7 && paddr[1:0] == 2'h0)
					rd_next = rsp_reg[paddr[4:2]];
				else
					rd_hit = 1'b0;
			end
		endcase
	end

	// data is captured in the setup cycle so it stands through the access cycle
	always @(posedge mclk)
	begin
		if (srst)
			prdata <= 32'h0000_0000;
		else if (psel & ~penable & ~pwrite)
			prdata <= rd_next;
	end

	// ****************************************
	// jack pin synchroniser and events
	// ****************************************
	always @(posedge mclk)
	begin
		if (srst)
		begin
			s1_reg   <= {NJACK{1'b0}};
			s2_reg   <= {NJACK{1'b0}};
			s3_reg   <= {NJACK{1'b0}};
			plug_reg <= {NJACK{1'b0}};
		end
		else
		begin
			s1_reg   <= jack_plug;
			s2_reg   <= s1_reg;
			s3_reg   <= s2_reg;
			// a change counts only when the last two stages agree
			plug_reg <= (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & plug_reg);
		end
	end

	// lowest jack whose state differs from what was last reported
	always @*
	begin
		ev_hit = 1'b0;
		ev_sel = 32'h0000_0000;
		for (jx = NJACK - 1; jx >= 0; jx = jx - 1)
		begin
			if (plug_reg[jx] != told_reg[jx])
			begin
				ev_hit = 1'b1;
				ev_sel = jx;
			end
		end
	end

	// one event slot; further changes wait in the told mismatch, so none is lost
	always @(posedge mclk)
	begin
		if (srst)
		begin
			told_reg      <= {NJACK{1'b0}};
			evt_valid_reg <= 1'b0;
			evt_type_reg  <= 32'h0000_0000;
			evt_data_reg  <= 32'h0000_0000;
		end
		else if (!evt_valid_reg && ev_hit)
		begin
			evt_valid_reg    <= 1'b1;
			evt_data_reg     <= ev_sel;
			evt_type_reg     <= plug_reg[ev_sel] ? `EVT_JACK_CONN : `EVT_JACK_DISC;
			told_reg[ev_sel] <= plug_reg[ev_sel];
		end
		else if (wr && paddr == `OFS_EVT_CTRL && pwdata[`EVT_PEND_BIT])
			evt_valid_reg <= 1'b0;
	end

	// ****************************************
	// per stream outputs
	// ****************************************
	always @*
	begin
		for (sx = 0; sx < NSTREAM; sx = sx + 1)
		begin
			stream_run[sx] = st_reg[sx] == `ST_RUNNING;
			tx_accept[sx]  = (st_reg[sx] == `ST_RUNNING) | ((st_reg[sx] == `ST_PREPARED) & ~DIR_MASK[sx]);
			poll_mode[sx]  = feat_reg[sx][`PCM_F_POLLING];
		end
	end

	// ****************************************
	// request interpreter
	// ****************************************
	always @(posedge mclk)
	begin
		if (srst)
		begin
			req_code_reg  <= 32'h0000_0000;
			req_index_reg <= 32'h0000_0000;
			req_arg0_reg  <= 32'h0000_0000;
			req_arg1_reg  <= 32'h0000_0000;
			req_arg2_reg  <= 32'h0000_0000;
			req_arg3_reg  <= 32'h0000_0000;
			status_reg    <= `RST_STATUS;
			remap_strobe  <= 1'b0;
			remap_jack    <= 32'h0000_0000;
			remap_assoc   <= 32'h0000_0000;
			remap_seq     <= 32'h0000_0000;
			for (i = 0; i < 8; i = i + 1)
				rsp_reg[i] <= 32'h0000_0000;
			for (i = 0; i < NSTREAM; i = i + 1)
			begin
				st_reg[i]   <= `ST_RELEASED;
				feat_reg[i] <= 32'h0000_0000;
			end
		end
		else
		begin
			remap_strobe <= 1'b0;
			// request words are frozen while a release is waiting
			if (wr && !busy)
			begin
				case (paddr)
					`OFS_REQ_CODE:  req_code_reg  <= pwdata;
					`OFS_REQ_INDEX: req_index_reg <= pwdata;
					`OFS_REQ_ARG0:  req_arg0_reg  <= pwdata;
					`OFS_REQ_ARG1:  req_arg1_reg  <= pwdata;
					`OFS_REQ_ARG2:  req_arg2_reg  <= pwdata;
					`OFS_REQ_ARG3:  req_arg3_reg  <= pwdata;
					default:        ;
				endcase
			end
			if (busy)
			begin
				if (!xfer_pending[req_index_reg])
				begin
					st_reg[req_index_reg] <= `ST_RELEASED;
					status_reg            <= {16'h0000, `S_OK};
				end
			end
			else if (go)
			begin
				for (i = 0; i < 8; i = i + 1)
					rsp_reg[i] <= 32'h0000_0000;
				status_reg <= {16'h0000, `S_OK};
				case (req_code_reg)
					`R_JACK_INFO:
					begin
						if (!jack_ok)
							status_reg <= {16'h0000, `S_BAD_MSG};
						else
						begin
							// jack info layout, pads stay zero
							rsp_reg[0] <= FN_NID;
							rsp_reg[1] <= jack_feat;
							rsp_reg[2] <= JACK_DEFCFG;
							rsp_reg[3] <= JACK_CAPS;
							rsp_reg[4] <= {31'h0000_0000, plug_reg[req_index_reg]};
						end
					end
					`R_JACK_REMAP:
					begin
						if (!jack_ok)
							status_reg <= {16'h0000, `S_BAD_MSG};
						else if (JACK_REMAP == 0)
							status_reg <= {16'h0000, `S_NOT_SUPP};
						else
						begin
							remap_strobe <= 1'b1;
							remap_jack   <= req_index_reg;
							remap_assoc  <= req_arg0_reg;
							remap_seq    <= req_arg1_reg;
						end
					end
					`R_PCM_INFO:
					begin
						if (!strm_ok)
							status_reg <= {16'h0000, `S_BAD_MSG};
						else
						begin
							rsp_reg[0] <= FN_NID;
							rsp_reg[1] <= adv_feat;
							rsp_reg[2] <= adv_fmts[31:0];
							rsp_reg[3] <= adv_fmts[63:32];
							rsp_reg[4] <= adv_rates[31:0];
							rsp_reg[5] <= adv_rates[63:32];
							rsp_reg[6] <= {8'h00, CH_MAX, CH_MIN, 7'h00, DIR_MASK[req_index_reg]};
						end
					end
					`R_PCM_SET_PARAMS:
					begin
						if (!strm_ok || cur_st == `ST_RUNNING || cur_st == `ST_STOPPED)
							status_reg <= {16'h0000, `S_BAD_MSG};
						else if (req_arg2_reg[`PCM_F_SHMEM_HOST] || req_arg2_reg[`PCM_F_SHMEM_GST])
							status_reg <= {16'h0000, `S_BAD_MSG};
						else if ((req_arg2_reg & ~adv_feat) != 32'h0000_0000 || sp_fmt > 8'h3f ||
							 !adv_fmts[sp_fmt[5:0]] || sp_rate > 8'h3f || !adv_rates[sp_rate[5:0]] ||
							 sp_ch < CH_MIN || sp_ch > CH_MAX)
							status_reg <= {16'h0000, `S_NOT_SUPP};
						else if (req_arg0_reg > BUF_CAP)
							status_reg <= {16'h0000, `S_NOT_SUPP};
						else
						begin
							st_reg[req_index_reg]   <= `ST_PARAMS;
							feat_reg[req_index_reg] <= req_arg2_reg;
						end
					end
					`R_PCM_PREPARE:
					begin
						if (!strm_ok || cur_st == `ST_RUNNING || cur_st == `ST_STOPPED)
							status_reg <= {16'h0000, `S_BAD_MSG};
						else
							st_reg[req_index_reg] <= `ST_PREPARED;
					end
					`R_PCM_START:
					begin
						if (!strm_ok || (cur_st != `ST_PREPARED && cur_st != `ST_STOPPED))
							status_reg <= {16'h0000, `S_BAD_MSG};
						else
							st_reg[req_index_reg] <= `ST_RUNNING;
					end
					`R_PCM_STOP:
					begin
						if (!strm_ok || cur_st != `ST_RUNNING)
							status_reg <= {16'h0000, `S_BAD_MSG};
						else
							st_reg[req_index_reg] <= `ST_STOPPED;
					end
					`R_PCM_RELEASE:
					begin
						if (!strm_ok || (cur_st != `ST_PREPARED && cur_st != `ST_STOPPED))
							status_reg <= {16'h0000, `S_BAD_MSG};
						// hold answer while data is in flight
						else if (xfer_pending[req_index_reg])
							status_reg <= 32'h8000_0000;
						else
							st_reg[req_index_reg] <= `ST_RELEASED;
					end
					default:
						status_reg <= {16'h0000, `S_NOT_SUPP};
				endcase
			end
		end
	end

endmodule // sound_jack_pcm_control

// File: dv/sound_ctl_asserts.sv
// port checker for the sound control block
`timescale 1ns/1ps
`include "sound_ctl_map.vh"
module sound_ctl_asserts #(
	parameter NSTREAM = 2
)(
	// clock and reset
	input logic               mclk,
	input logic               srst,
	// apb
	input logic               psel,
	input logic               penable,
	input logic               pwrite,
	input logic [7:0]         paddr,
	input logic [31:0]        pwdata,
	input logic               pready,
	input logic               pslverr,
	// stream and remap outputs
	input logic [NSTREAM-1:0] stream_run,
	input logic [NSTREAM-1:0] tx_accept,
	input logic [NSTREAM-1:0] poll_mode,
	input logic               remap_strobe,
	input logic [31:0]        remap_jack,
	input logic [31:0]        remap_assoc,
	input logic [31:0]        remap_seq
);
	// ****************************************
	// helper logic
	// ****************************************
	logic [31:0] code_reg;
	wire         wr_acc = psel && penable && pwrite;
	wire         go     = wr_acc && paddr == `OFS_REQ_GO;
	wire         bad_ad = paddr > `OFS_STRM_STATE || paddr[1:0] != 2'h0;
	// code kept so a state change can be tied to the command that caused it
	always @(posedge mclk)
		if (srst)
			code_reg <= 32'h0;
		else if (wr_acc && paddr == `OFS_REQ_CODE)
			code_reg <= pwdata;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (srst);
	// ****************************************
	// properties
	// ****************************************
	sequence s_pulse;
		remap_strobe ##1 !remap_strobe;
	endsequence
	property p_ready; psel |-> pready; endproperty
	property p_slverr; psel && penable |-> pslverr == bad_ad; endproperty
	property p_start; $rose(stream_run[0]) |-> ($past(go) || $past(go, 2)) && code_reg == `R_PCM_START; endproperty
	property p_stop; $fell(stream_run[0]) |-> ($past(go) || $past(go, 2)) && code_reg == `R_PCM_STOP; endproperty
	property p_accept; tx_accept[1] == stream_run[1] && !(stream_run[0] && !tx_accept[0]); endproperty
	property p_poll; $changed(poll_mode) |-> $past(go) || $past(go, 2); endproperty
	property p_strobe; remap_strobe |-> s_pulse; endproperty
	property p_remap_src; remap_strobe |-> code_reg == `R_JACK_REMAP && ($past(go) || $past(go, 2)); endproperty
	property p_remap_hold;
		$changed({remap_jack, remap_assoc, remap_seq}) |-> remap_strobe || $past(remap_strobe);
	endproperty
	a_ready: assert property (p_ready) else $error("pready low during a transfer");
	a_slverr: assert property (p_slverr) else $error("pslverr does not match address map");
	a_start: assert property (p_start) else $error("stream ran without a start command");
	a_stop: assert property (p_stop) else $error("stream halted without a stop command");
	a_accept: assert property (p_accept) else $error("data accept wrong for stream state");
	a_poll: assert property (p_poll) else $error("polling mode changed without a command");
	a_strobe: assert property (p_strobe) else $error("remap strobe longer than one cycle");
	a_remap_src: assert property (p_remap_src) else $error("remap strobe without remap command");
	a_remap_hold: assert property (p_remap_hold) else $error("remap values changed without strobe");
endmodule // sound_ctl_asserts

bind sound_jack_pcm_control sound_ctl_asserts #(.NSTREAM(NSTREAM)) u_chk (.mclk(mclk), .srst(srst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
	.stream_run(stream_run), .tx_accept(tx_accept), .poll_mode(poll_mode), .remap_strobe(remap_strobe),
	.remap_jack(remap_jack), .remap_assoc(remap_assoc), .remap_seq(remap_seq));

// File: dv/sound_stream_peer.sv
// far-side stream data source keeping transfers pending around stream activity
`timescale 1ns/1ps
module sound_stream_peer #(
	parameter N = 2
)(
	// clock and reset
	input  wire         mclk,
	input  wire         srst,
	// stream side
	input  wire [N-1:0] tx_accept,
	input  wire [7:0]   lag,
	output reg  [N-1:0] xfer_pending
);
	reg [7:0] tail_reg [0:N-1];
	integer   i;
	// lag models a slow host still draining buffers after the stream stops
	always @(posedge mclk)
	begin
		for (i = 0; i < N; i = i + 1)
		begin
			if (srst || tx_accept[i])
				tail_reg[i] <= srst ? 8'h0 : lag;
			else if (tail_reg[i] != 8'h0)
				tail_reg[i] <= tail_reg[i] - 8'h1;
			xfer_pending[i] <= !srst && (tx_accept[i] || tail_reg[i] != 8'h0);
		end
	end
endmodule // sound_stream_peer

// File: dv/test_sound_jack_pcm_control.sv
// self-checking bench for the sound control block
`timescale 1ns/1ps
`include "sound_ctl_map.vh"
module test_sound_jack_pcm_control;
	reg         mclk, srst, psel, penable, pwrite;
	reg  [7:0]  paddr, lag;
	reg  [31:0] pwdata, v;
	reg  [1:0]  jack_plug;
	wire [31:0] prdata, remap_jack, remap_assoc, remap_seq;
	wire        pready, pslverr, remap_strobe;
	wire [1:0]  xfer_pending, stream_run, tx_accept, poll_mode;
	integer     n_mismatch, cmp_count, k;
	sound_jack_pcm_control uut (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .jack_plug(jack_plug),
		.xfer_pending(xfer_pending), .stream_run(stream_run), .tx_accept(tx_accept), .poll_mode(poll_mode),
		.remap_strobe(remap_strobe), .remap_jack(remap_jack), .remap_assoc(remap_assoc), .remap_seq(remap_seq));
	sound_stream_peer peer (.mclk(mclk), .srst(srst), .tx_accept(tx_accept), .lag(lag), .xfer_pending(xfer_pending));
	// ****************************************
	// tasks
	// ****************************************
	task give_verdict;
	begin
		$display("compares %0d, mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	end
	endtask
	task chk_reg(input [31:0] g, input [31:0] e);
	begin
		cmp_count = cmp_count + 1;
		if (g !== e)
		begin
			n_mismatch = n_mismatch + 1;
			$display("CHECK FAILED at %0t: word %h, expected %h", $time, g, e);
		end
	end
	endtask
	task chk_pin(input [1:0] g, input [1:0] e);
	begin
		cmp_count = cmp_count + 1;
		if (g !== e)
		begin
			n_mismatch = n_mismatch + 1;
			$display("CHECK FAILED at %0t: pins %b, expected %b", $time, g, e);
		end
	end
	endtask
	// one apb transfer; request held until pready is seen high
	task xfer(input w, input [7:0] a, input [31:0] d);
	begin
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1)
			@(posedge mclk);
		v = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	end
	endtask
	task rdc(input [7:0] a, input [31:0] e);
	begin
		xfer(1'b0, a, 32'h0);
		chk_reg(v, e);
	end
	endtask
	task cmd(input [31:0] c, input [31:0] i, input [31:0] a0, input [31:0] a1, input [31:0] a2, input [31:0] a3,
		input [31:0] e);
	begin
		xfer(1'b1, `OFS_REQ_CODE, c);
		xfer(1'b1, `OFS_REQ_INDEX, i);
		xfer(1'b1, `OFS_REQ_ARG0, a0);
		xfer(1'b1, `OFS_REQ_ARG1, a1);
		xfer(1'b1, `OFS_REQ_ARG2, a2);
		xfer(1'b1, `OFS_REQ_ARG3, a3);
		xfer(1'b1, `OFS_REQ_GO, 32'h0);
		rdc(`OFS_RSP_STATUS, e);
	end
	endtask
	// legal parameters: polling only, 48000 rate, format 2, two channels, buffer four periods
	task step(input [31:0] c, input [31:0] e, input [31:0] s);
	begin
		cmd(c, 32'h0, 32'h1000, 32'h400, 32'h4, 32'h0007_0202, e);
		rdc(`OFS_STRM_STATE, s);
	end
	endtask
	task plug(input [1:0] p, input [31:0] t);
	begin
		jack_plug <= p;
		repeat (10) @(posedge mclk);
		rdc(`OFS_EVT_CTRL, 32'h1);
		rdc(`OFS_EVT_TYPE, t);
		rdc(`OFS_EVT_DATA, 32'h1);
		xfer(1'b1, `OFS_EVT_CTRL, 32'h1);
	end
	endtask
	// ****************************************
	// clock, watchdog and tests
	// ****************************************
	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	initial
	begin
		repeat (20000) @(posedge mclk);
		n_mismatch = n_mismatch + 1;
		give_verdict;
	end
	initial
	begin
		n_mismatch = 0;
		cmp_count = 0;
		{psel, penable, pwrite, srst} = 4'h1;
		paddr = 8'h0;
		pwdata = 32'h0;
		jack_plug = 2'h0;
		lag = 8'h0;
		repeat (5) @(posedge mclk);
		srst <= 1'b0;
		rdc(`OFS_RSP_STATUS, `RST_STATUS);
		rdc(8'h50, 32'h0);
		$display("test reset done");
		cmd(`R_JACK_INFO, 0, 0, 0, 0, 0, 32'h8000);
		rdc(`OFS_RSP_W0 + 8'h04, 32'h1);
		rdc(`OFS_RSP_W0 + 8'h10, 32'h0);
		rdc(`OFS_RSP_W0 + 8'h14, 32'h0);
		plug(2'h2, `EVT_JACK_CONN);
		cmd(`R_JACK_INFO, 1, 0, 0, 0, 0, 32'h8000);
		rdc(`OFS_RSP_W0 + 8'h10, 32'h1);
		plug(2'h0, `EVT_JACK_DISC);
		cmd(`R_JACK_INFO, 2, 0, 0, 0, 0, 32'h8001);
		cmd(`R_JACK_REMAP, 1, 5, 9, 0, 0, 32'h8000);
		chk_reg(remap_jack ^ remap_assoc ^ remap_seq, 32'hd);
		$display("test jacks done");
		cmd(`R_PCM_INFO, 0, 0, 0, 0, 0, 32'h8000);
		rdc(`OFS_RSP_W0 + 8'h04, 32'h1c);
		rdc(`OFS_RSP_W0 + 8'h08, 32'h4);
		rdc(`OFS_RSP_W0 + 8'h10, 32'hc0);
		rdc(`OFS_RSP_W0 + 8'h18, 32'h0002_0100);
		rdc(`OFS_RSP_W0 + 8'h1c, 32'h0);
		cmd(`R_PCM_INFO, 1, 0, 0, 0, 0, 32'h8000);
		rdc(`OFS_RSP_W0 + 8'h18, 32'h0002_0101);
		$display("test stream info done");
		step(`R_PCM_START, 32'h8001, 0);
		step(`R_PCM_SET_PARAMS, 32'h8000, 1);
		chk_pin(poll_mode, 2'h1);
		step(`R_PCM_RELEASE, 32'h8001, 1);
		step(`R_PCM_PREPARE, 32'h8000, 2);
		chk_pin(tx_accept, 2'h1);
		step(`R_PCM_START, 32'h8000, 3);
		chk_pin(stream_run, 2'h1);
		step(`R_PCM_PREPARE, 32'h8001, 3);
		step(`R_PCM_STOP, 32'h8000, 4);
		step(`R_PCM_START, 32'h8000, 3);
		lag <= 8'h28;
		step(`R_PCM_STOP, 32'h8000, 4);
		cmd(`R_PCM_RELEASE, 0, 0, 0, 0, 0, 32'h8000_0000);
		chk_pin(xfer_pending, 2'h1);
		for (k = 0; k < 100 && v[31] !== 1'b0; k = k + 1)
			xfer(1'b0, `OFS_RSP_STATUS, 32'h0);
		chk_reg(v, 32'h8000);
		chk_pin(xfer_pending, 2'h0);
		lag <= 8'h0;
		step(`R_PCM_PREPARE, 32'h8000, 2);
		$display("test lifecycle done");
		cmd(`R_PCM_SET_PARAMS, 0, 32'h1000, 32'h400, 32'h1, 32'h0007_0202, 32'h8001);
		cmd(`R_PCM_SET_PARAMS, 0, 32'h2_0000, 32'h400, 32'h4, 32'h0007_0202, 32'h8002);
		cmd(`R_PCM_SET_PARAMS, 0, 32'h1000, 32'h400, 32'h3, 32'h0007_0202, 32'h8001);
		cmd(`R_PCM_SET_PARAMS, 0, 32'h1000, 32'h400, 32'h4, 32'h0008_0202, 32'h8002);
		cmd(`R_PCM_SET_PARAMS, 0, 32'h1000, 32'h400, 32'h4, 32'h0007_0203, 32'h8002);
		rdc(`OFS_STRM_STATE, 32'h2);
		cmd(32'h0000_0200, 0, 0, 0, 0, 0, 32'h8002);
		cmd(`R_PCM_PREPARE, 2, 0, 0, 0, 0, 32'h8001);
		rdc(`OFS_STRM_STATE, 32'h0);
		$display("test refusals done");
		give_verdict;
	end
endmodule // test_sound_jack_pcm_control
